// ==== quad_rail_pkg.sv ====
// package: constants and types for the four-rail sequencer core
package quad_rail_pkg;
   // ==========================================================
   // timing
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned QUAL_LONG_MS = 190;
   localparam int unsigned QUAL_SHORT_US = 30;
   localparam int unsigned QUAL_LONG_CYC = QUAL_LONG_MS * 1000 * CLK_MHZ;
   localparam int unsigned QUAL_SHORT_CYC = QUAL_SHORT_US * CLK_MHZ;
   localparam int unsigned CNT_W = 26;
   localparam logic [CNT_W-1:0] CNT_RESET = 26'h0;

   // ==========================================================
   // states
   typedef enum logic [2:0] {
      st_reset = 3'h0,
      st_first_on = 3'h1,
      st_two_on = 3'h2,
      st_three_on = 3'h3,
      st_all_good = 3'h4
   } seq_state_t;

   typedef struct packed {
      logic primary_rail_sense;
      logic second_rail_sense;
      logic third_rail_sense;
      logic final_rail_sense;
   } sense_t;

   typedef struct packed {
      logic first_regulator_enable;
      logic second_regulator_enable;
      logic third_regulator_enable;
      logic power_good;
   } outs_t;

   localparam outs_t OUTS_RESET = 4'h0;

   typedef struct packed {
      sense_t sync1;
      sense_t sync2;
      seq_state_t state;
      logic [CNT_W-1:0] cnt;
      outs_t outs;
   } core_state_t;
endpackage

// ==== quad_rail_sequencer_core.sv ====
// module: four-rail supply sequencing state machine
module quad_rail_sequencer_core
   import quad_rail_pkg::*;
#(
   // qualification counts in clock cycles, shortened only for simulation
   parameter int unsigned LONG_CYC = QUAL_LONG_CYC,
   parameter int unsigned SHORT_CYC = QUAL_SHORT_CYC
)
(
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire sense_t rail_sense_in,
   output logic first_regulator_enable_out,
   output logic second_regulator_enable_out,
   output logic third_regulator_enable_out,
   output logic power_good_out
);

   core_state_t cur_q;
   core_state_t cur_d;
   sense_t s;
   logic need_ok;
   logic [CNT_W-1:0] need_cyc;

   assign s = cur_q.sync2;

   // ==========================================================
   // next state
   always_comb
   begin
      cur_d = cur_q;
      cur_d.sync1 = rail_sense_in;
      cur_d.sync2 = cur_q.sync1;
      need_ok = 1'b0;
      need_cyc = CNT_W'(SHORT_CYC);
      case (cur_q.state)
         st_reset:
         begin
            need_ok = s.primary_rail_sense;
            need_cyc = CNT_W'(LONG_CYC);
         end
         st_first_on:
            need_ok = s.primary_rail_sense && s.second_rail_sense;
         st_two_on:
            need_ok = s.primary_rail_sense && s.second_rail_sense && s.third_rail_sense;
         st_three_on:
         begin
            need_ok = &s;
            need_cyc = CNT_W'(LONG_CYC);
         end
         st_all_good:
            need_ok = !(s.second_rail_sense && s.third_rail_sense && s.final_rail_sense);
         default:
            need_ok = 1'b0;
      endcase
      if (cur_q.state == st_all_good && !s.primary_rail_sense)
      begin
         cur_d.state = st_reset;
         cur_d.cnt = CNT_RESET;
      end
      else if (!need_ok)
         cur_d.cnt = CNT_RESET;
      else if (cur_q.cnt < need_cyc - CNT_W'(1))
         cur_d.cnt = cur_q.cnt + CNT_W'(1);
      else
      begin
         cur_d.cnt = CNT_RESET;
         case (cur_q.state)
            st_reset: cur_d.state = st_first_on;
            st_first_on: cur_d.state = st_two_on;
            st_two_on: cur_d.state = st_three_on;
            st_three_on: cur_d.state = st_all_good;
            st_all_good: cur_d.state = st_three_on;
            default: cur_d.state = st_reset;
         endcase
      end
      cur_d.outs.first_regulator_enable = cur_d.state != st_reset;
      cur_d.outs.second_regulator_enable = cur_d.state inside {st_two_on, st_three_on, st_all_good};
      cur_d.outs.third_regulator_enable = cur_d.state inside {st_three_on, st_all_good};
      // power-good drops at once on any low synced rail
      cur_d.outs.power_good = cur_d.state == st_all_good && (&s);
   end

   // ==========================================================
   // registers
   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
      begin
         cur_q.sync1 <= 4'h0;
         cur_q.sync2 <= 4'h0;
         cur_q.state <= st_reset;
         cur_q.cnt <= CNT_RESET;
         cur_q.outs <= OUTS_RESET;
      end
      else
         cur_q <= cur_d;
   end

   assign first_regulator_enable_out = cur_q.outs.first_regulator_enable;
   assign second_regulator_enable_out = cur_q.outs.second_regulator_enable;
   assign third_regulator_enable_out = cur_q.outs.third_regulator_enable;
   assign power_good_out = cur_q.outs.power_good;

   // ==========================================================
   // checks
   property p_reset_low;
      @(posedge ref_clk_in) srst_in |=> cur_q.outs == 4'h0;
   endproperty
   a_reset_low: assert property (p_reset_low) else $error("outputs not low after reset");

   property p_pg_needs_all;
      @(posedge ref_clk_in) disable iff (srst_in) power_good_out |-> cur_q.state == st_all_good;
   endproperty
   a_pg_needs_all: assert property (p_pg_needs_all) else $error("power good outside all-good");

   property p_pg_drop;
      @(posedge ref_clk_in) disable iff (srst_in) !(&s) |=> !power_good_out;
   endproperty
   a_pg_drop: assert property (p_pg_drop) else $error("power good held with low rail");

   property p_primary_fault;
      @(posedge ref_clk_in) disable iff (srst_in)
         (cur_q.state == st_all_good && !s.primary_rail_sense) |=>
         !first_regulator_enable_out && !second_regulator_enable_out && !third_regulator_enable_out;
   endproperty
   a_primary_fault: assert property (p_primary_fault) else $error("enables held on primary fault");

   property p_first_qual;
      @(posedge ref_clk_in) disable iff (srst_in)
         $rose(first_regulator_enable_out) |-> $past(cur_q.cnt) == CNT_W'(LONG_CYC - 1);
   endproperty
   a_first_qual: assert property (p_first_qual) else $error("first enable without long delay");

   property p_second_step;
      @(posedge ref_clk_in) disable iff (srst_in)
         $rose(second_regulator_enable_out) |-> $past(cur_q.state) == st_first_on;
   endproperty
   a_second_step: assert property (p_second_step) else $error("second enable out of order");

   property p_third_step;
      @(posedge ref_clk_in) disable iff (srst_in)
         $rose(third_regulator_enable_out) |-> $past(cur_q.state) == st_two_on
            && $past(cur_q.cnt) == CNT_W'(SHORT_CYC - 1);
   endproperty
   a_third_step: assert property (p_third_step) else $error("third enable out of order");

   property p_restart;
      @(posedge ref_clk_in) disable iff (srst_in)
         (cur_q.state == st_first_on && !s.second_rail_sense) |=> cur_q.cnt == CNT_RESET;
   endproperty
   a_restart: assert property (p_restart) else $error("delay not restarted");

   // ==========================================================
   // step sequences
   sequence s_primary_fault;
      cur_q.state == st_all_good && !s.primary_rail_sense;
   endsequence

   sequence s_back_in_reset;
      cur_q.state == st_reset && cur_q.cnt == CNT_RESET && !first_regulator_enable_out;
   endsequence

   sequence s_enter_good;
      cur_q.state == st_three_on && cur_d.state == st_all_good;
   endsequence

   sequence s_rail_lost;
      cur_q.state == st_all_good && s.primary_rail_sense && cur_d.state == st_three_on;
   endsequence

   // ==========================================================
   // step checks
   property p_first_from_reset;
      @(posedge ref_clk_in) disable iff (srst_in)
         $rose(first_regulator_enable_out) |-> $past(cur_q.state) == st_reset;
   endproperty
   a_first_from_reset: assert property (p_first_from_reset) else $error("first enable not from reset");

   property p_first_go;
      @(posedge ref_clk_in) disable iff (srst_in)
         (cur_q.state == st_reset && s.primary_rail_sense && cur_q.cnt == CNT_W'(LONG_CYC - 1))
            |=> first_regulator_enable_out;
   endproperty
   a_first_go: assert property (p_first_go) else $error("first enable missing after primary delay");

   property p_second_qual;
      @(posedge ref_clk_in) disable iff (srst_in)
         $rose(second_regulator_enable_out) |-> $past(cur_q.cnt) == CNT_W'(SHORT_CYC - 1);
   endproperty
   a_second_qual: assert property (p_second_qual) else $error("second enable without short delay");

   property p_good_entry;
      @(posedge ref_clk_in) disable iff (srst_in)
         s_enter_good |-> (&s) && cur_q.cnt == CNT_W'(LONG_CYC - 1);
   endproperty
   a_good_entry: assert property (p_good_entry) else $error("all-good without long delay");

   property p_fault_rerun;
      @(posedge ref_clk_in) disable iff (srst_in)
         s_primary_fault |=> s_back_in_reset;
   endproperty
   a_fault_rerun: assert property (p_fault_rerun) else $error("primary fault not back to reset");

   property p_rail_lost;
      @(posedge ref_clk_in) disable iff (srst_in)
         s_rail_lost |=> cur_q.state == st_three_on && !power_good_out
            && first_regulator_enable_out && second_regulator_enable_out && third_regulator_enable_out;
   endproperty
   a_rail_lost: assert property (p_rail_lost) else $error("rail loss did not keep enables");

   property p_stall;
      @(posedge ref_clk_in) disable iff (srst_in)
         (cur_q.state inside {st_first_on, st_two_on, st_three_on} && !s.primary_rail_sense)
            |=> $stable(cur_q.state);
   endproperty
   a_stall: assert property (p_stall) else $error("state moved while primary low");

endmodule // quad_rail_sequencer_core

// ==== rail_regulator_model.sv ====
// external regulators: each enable brings up the next sensed rail
module rail_regulator_model
   import quad_rail_pkg::*;
#(
   parameter int RISE_CYC = 20
)
(
   input wire logic ref_clk_in,
   input wire logic primary_in,
   input wire logic [2:0] enables_in,
   input wire logic [2:0] drop_in,
   output sense_t rail_sense_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_q [3] = '{0, 0, 0};
   // ==========================================================
   // rail rises slowly, collapses at once when disabled
   always @(posedge ref_clk_in)
   begin
      for (int i = 0; i < 3; i++)
      begin
         cnt_q[i] <= !enables_in[2-i] ? 0 : (cnt_q[i] < RISE_CYC) ? cnt_q[i] + 1 : cnt_q[i];
      end
   end
   // drop_in sags a sensed rail without touching its regulator
   assign rail_sense_out = {primary_in, cnt_q[0] == RISE_CYC && !drop_in[2], cnt_q[1] == RISE_CYC && !drop_in[1],
      cnt_q[2] == RISE_CYC && !drop_in[0]};
endmodule // rail_regulator_model

// ==== testbench.sv ====
// self-checking bench for the four-rail sequencer core
module testbench;
   import quad_rail_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // shortened delays so a full sequence fits the run
   localparam int unsigned LONG_SIM = 400;
   localparam int unsigned SHORT_SIM = 40;
   localparam int RISE_SIM = 20;
   // primary high to first enable: two sync stages, long count, register
   localparam int FIRST_AT = LONG_SIM + 2;
   // one regulator step: rail rise, sync, short count, register
   localparam int STEP = RISE_SIM + SHORT_SIM + 2;
   localparam int GOOD_AT = FIRST_AT + 2 * STEP + RISE_SIM + LONG_SIM + 2;
   localparam int LIMIT_CYC = 10000;
   logic ref_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic primary = 1'b1;
   logic [2:0] drop = 3'h0;
   sense_t rail_sense;
   logic [3:0] outs;
   logic [3:0] exp_q [$];
   event check_ev;
   int err_count = 0;
   int n_compared = 0;
   int seed = 38343;
   int now = 0;
   always #2.5 ref_clk_in = ~ref_clk_in;
   rail_regulator_model #(.RISE_CYC(RISE_SIM)) reg_u (.ref_clk_in(ref_clk_in), .primary_in(primary),
      .enables_in(outs[3:1]), .drop_in(drop), .rail_sense_out(rail_sense));
   quad_rail_sequencer_core #(.LONG_CYC(LONG_SIM), .SHORT_CYC(SHORT_SIM)) dut_u (.ref_clk_in(ref_clk_in),
      .srst_in(srst_in), .rail_sense_in(rail_sense), .first_regulator_enable_out(outs[3]),
      .second_regulator_enable_out(outs[2]), .third_regulator_enable_out(outs[1]), .power_good_out(outs[0]));
   // ==========================================================
   // checking
   task automatic compare(input logic [3:0] seen, input logic [3:0] expd);
      n_compared++;
      if (seen !== expd)
      begin
         err_count++;
         $display("wrong value outputs expected %h seen %h", expd, seen);
      end
   endtask
   always @(check_ev)
   begin
      compare(outs, exp_q.pop_front());
   end
   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // stimulus
   // advance to a rising edge counted from the last phase start
   task automatic goto(input int at);
      repeat (at - now) @(posedge ref_clk_in);
      now = at;
   endtask
   // note the expected outputs once settled
   task automatic check(input logic [3:0] expd);
      @(negedge ref_clk_in);
      exp_q.push_back(expd);
      -> check_ev;
   endtask
   // full sequence from primary going high at phase start
   task automatic power_up();
      goto(FIRST_AT - 20);
      check(4'h0);
      goto(FIRST_AT + 30);
      check(4'h8);
      goto(FIRST_AT + STEP + 30);
      check(4'hC);
      goto(FIRST_AT + 2 * STEP + 30);
      check(4'hE);
      goto(GOOD_AT - 20);
      check(4'hE);
      goto(GOOD_AT + 20);
      check(4'hF);
   endtask
   initial
   begin
      repeat (12) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      check(4'h0);
      $display("reset hold done");
      for (int i = 0; i < 3000; i++)
      begin
         @(posedge ref_clk_in);
         primary <= 1'($random(seed));
         if (i % 100 == 99)
            check(4'h0);
      end
      @(posedge ref_clk_in);
      primary <= 1'b0;
      $display("random primary done");
      repeat (10) @(posedge ref_clk_in);
      primary <= 1'b1;
      now = 0;
      power_up();
      $display("power-up sequence done");
      goto(GOOD_AT + 40);
      primary <= 1'b0;
      goto(GOOD_AT + 50);
      check(4'h0);
      goto(GOOD_AT + 60);
      primary <= 1'b1;
      now = 0;
      power_up();
      $display("primary fault rerun done");
      goto(GOOD_AT + 40);
      drop <= 3'h1;
      goto(GOOD_AT + 46);
      check(4'hE);
      goto(GOOD_AT + 50);
      drop <= 3'h0;
      goto(GOOD_AT + 70);
      check(4'hF);
      goto(GOOD_AT + 80);
      drop <= 3'h2;
      goto(GOOD_AT + 120 + SHORT_SIM);
      check(4'hE);
      goto(GOOD_AT + 200);
      drop <= 3'h0;
      goto(GOOD_AT + 180 + LONG_SIM);
      check(4'hE);
      goto(GOOD_AT + 220 + LONG_SIM);
      check(4'hF);
      $display("rail dropout done");
      goto(GOOD_AT + 240 + LONG_SIM);
      srst_in <= 1'b1;
      goto(GOOD_AT + 242 + LONG_SIM);
      check(4'h0);
      goto(GOOD_AT + 252 + LONG_SIM);
      srst_in <= 1'b0;
      now = 0;
      goto(FIRST_AT - 20);
      check(4'h0);
      goto(FIRST_AT + 5);
      primary <= 1'b0;
      goto(FIRST_AT + 15);
      primary <= 1'b1;
      goto(FIRST_AT + 30);
      check(4'h8);
      $display("mid-run reset done");
      end_sim();
   end
   initial
   begin
      repeat (LIMIT_CYC) @(posedge ref_clk_in);
      err_count++;
      end_sim();
   end
endmodule // testbench
